// File: rtl/rtcs_regs.vh
// Constants for the serial slave access block of the real-time clock.
// Assumes inclusion by bare name from the design files.
`ifndef RTCS_REGS_VH
`define RTCS_REGS_VH
`define RTCS_SLAVE_ADDR 7'h68
`define RTCS_NUM_LOC 5'h14
`define RTCS_LAST_LOC 5'h13
`define RTCS_LAST_CLK_LOC 5'h07
`define RTCS_PTR_RST 5'h00
`define RTCS_CLK_HZ 10000000
`define RTCS_WP_RECOVERY_US 1000
`define RTCS_WP_CYCLES ((`RTCS_WP_RECOVERY_US * (`RTCS_CLK_HZ / 1000000)))
`define RTCS_FIFO_DEPTH 8
`endif

// File: rtl/rtcs_fifo.v
// Small synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module rtcs_fifo #(
    parameter WIDTH = 13,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire core_clk,
    input wire srst,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wp_r;
    reg [AW-1:0] rp_r;
    reg [AW:0] cnt_r;
    wire push;
    wire pop;

    assign in_ready = (cnt_r != DEPTH[AW:0]);
    assign out_valid = (cnt_r != {(AW+1){1'b0}});
    assign out_data = mem_r[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge core_clk) begin
        if (srst) begin
            wp_r <= {AW{1'b0}};
            rp_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                    wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                    rp_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

    always @(posedge core_clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end
endmodule // rtcs_fifo
`default_nettype wire

// File: rtl/rtcs_slave.v
// Two-wire serial slave front end for a 20-location clock register space.
// Assumes SCL and SDA arrive synchronous to core_clk and are oversampled;
// the register store itself lives outside and answers reads in one cycle.
`timescale 1ns/100ps
`default_nettype none
`include "rtcs_regs.vh"
// Function
// - Join a transfer only after START plus matching seven-bit slave address.
// - Twenty locations reached sequentially by the pointer, wrapping after last.
// - Power fail aborts access, clears pointer, ignores bus until cleared.
// - After power returns, keep writes blocked for the recovery interval.
// - START is SDA falling while SCL high.
// - STOP is SDA rising while SCL high.
// - SDA changes only while SCL low; one SCL pulse per bit.
// - Eight-bit bytes each followed by a ninth acknowledge bit.
// - Acknowledger holds SDA low through the acknowledge high phase.
// - On master not-acknowledge, device releases SDA for STOP.
// - No limit on bytes between START and STOP.
// - After write address and acknowledge, next byte loads the pointer.
// - Read address transmits byte at pointer, continuing until STOP.
// - Pointer advances only on an acknowledge clock.
// - Read without pointer write starts at last pointer value.
// - Write data bytes stored at pointer, pointer increments on acknowledge.
// - Acknowledge slave address, word address and every data byte; code withholds data acknowledge on full FIFO or recovery.
// - Freeze clock copy while pointer in clock area, resume on STOP.
// - Square wave has highest priority on the multi-function output.
// - Completed write to a clock location resets the divider chain.
module rtcs_slave #(
    parameter WP_CYCLES = `RTCS_WP_CYCLES
) (
    input wire core_clk,
    input wire srst,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output reg sda_oe,
    input wire power_fail,
    output reg [4:0] reg_addr,
    input wire [7:0] reg_rdata,
    output wire wr_valid,
    input wire wr_ready,
    output wire [4:0] wr_addr,
    output wire [7:0] wr_data,
    output reg update_freeze,
    output reg divider_reset,
    input wire sqw_enable,
    input wire sqw_level,
    input wire alt_out_low,
    output reg multi_function_output_oe
);
    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    localparam ST_IDLE = 7'b0000001;
    localparam ST_ADDR = 7'b0000010;
    localparam ST_AACK = 7'b0000100;
    localparam ST_RX = 7'b0001000;
    localparam ST_RACK = 7'b0010000;
    localparam ST_TX = 7'b0100000;
    localparam ST_FETCH = 7'b1000000;

    // ------------------------------------------------------------------
    // Registers and nets
    // ------------------------------------------------------------------
    reg [6:0] state_r;
    reg scl_r;
    reg sda_r;
    reg [7:0] shift_r;
    reg [3:0] bit_r;
    reg [4:0] ptr_r;
    reg ptr_phase_r;
    reg rd_mode_r;
    reg wr_clk_r;
    reg mack_r;
    reg fetch_r;
    reg pf_r;
    reg [31:0] wp_cnt_r;
    reg wp_block_r;
    reg fifo_valid_r;
    reg [12:0] fifo_in_r;
    wire fifo_ready;
    wire [12:0] fifo_out;
    wire start_det;
    wire stop_det;
    wire scl_rise;
    wire scl_fall;
    wire blocked;
    wire [4:0] ptr_inc;

    // ------------------------------------------------------------------
    // Bus conditions
    // ------------------------------------------------------------------
    // SCL must be high on both samples, so an edge is never a condition
    assign start_det = scl_in && scl_r && sda_r && !sda_in;
    assign stop_det = scl_in && scl_r && !sda_r && sda_in;
    assign scl_rise = scl_in && !scl_r;
    assign scl_fall = !scl_in && scl_r;
    assign blocked = pf_r || power_fail;
    assign ptr_inc = (ptr_r == `RTCS_LAST_LOC) ? `RTCS_PTR_RST :
        ptr_r + 5'h01;
    assign sda_out = 1'b0;

    // ------------------------------------------------------------------
    // Write path buffering
    // ------------------------------------------------------------------
    // Drops the byte and the transfer by withholding acknowledge if the store lags behind.
    rtcs_fifo #(
        .WIDTH(13),
        .DEPTH(`RTCS_FIFO_DEPTH),
        .AW(3)
    ) u_fifo (
        .core_clk(core_clk),
        .srst(srst),
        .in_valid(fifo_valid_r),
        .in_ready(fifo_ready),
        .in_data(fifo_in_r),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(fifo_out)
    );
    assign wr_addr = fifo_out[12:8];
    assign wr_data = fifo_out[7:0];

    // ------------------------------------------------------------------
    // Power fail and write-protect recovery
    // ------------------------------------------------------------------
    // Recovery counts from the last cycle power_fail was seen;
    // address and pointer bytes still pass, only stores wait.
    always @(posedge core_clk) begin
        if (srst) begin
            pf_r <= 1'b0;
            wp_cnt_r <= 32'h00000000;
            wp_block_r <= 1'b0;
        end else begin
            pf_r <= power_fail;
            if (power_fail) begin
                wp_block_r <= 1'b1;
                wp_cnt_r <= 32'h00000000;
            end else if (wp_block_r) begin
                if (wp_cnt_r >= WP_CYCLES - 1) begin
                    wp_block_r <= 1'b0;
                end
                wp_cnt_r <= wp_cnt_r + 32'h00000001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Store address
    // ------------------------------------------------------------------
    // One cycle behind ptr_r; read fetches wait for it
    always @(posedge core_clk) begin
        if (srst) begin
            reg_addr <= `RTCS_PTR_RST;
        end else begin
            reg_addr <= ptr_r;
        end
    end

    // ------------------------------------------------------------------
    // Bus protocol engine
    // ------------------------------------------------------------------
    // Edge flags compare against last cycle's samples, so each
    // bus event is seen on exactly one clock
    always @(posedge core_clk) begin
        if (srst) begin
            state_r <= ST_IDLE;
            scl_r <= 1'b1;
            sda_r <= 1'b1;
            shift_r <= 8'h00;
            bit_r <= 4'h0;
            ptr_r <= `RTCS_PTR_RST;
            ptr_phase_r <= 1'b0;
            rd_mode_r <= 1'b0;
            wr_clk_r <= 1'b0;
            mack_r <= 1'b0;
            sda_oe <= 1'b0;
            fetch_r <= 1'b0;
            update_freeze <= 1'b0;
            divider_reset <= 1'b0;
            fifo_valid_r <= 1'b0;
            fifo_in_r <= 13'h0000;
        end else begin
            scl_r <= scl_in;
            sda_r <= sda_in;
            divider_reset <= 1'b0;
            if (fifo_valid_r && fifo_ready) begin
                fifo_valid_r <= 1'b0;
            end
            if (blocked) begin
                state_r <= ST_IDLE;
                ptr_r <= `RTCS_PTR_RST;
                sda_oe <= 1'b0;
                update_freeze <= 1'b0;
                wr_clk_r <= 1'b0;
            end else if (stop_det) begin
                state_r <= ST_IDLE;
                sda_oe <= 1'b0;
                update_freeze <= 1'b0;
                divider_reset <= wr_clk_r;
                wr_clk_r <= 1'b0;
            end else if (start_det) begin
                state_r <= ST_ADDR;
                bit_r <= 4'h0;
                sda_oe <= 1'b0;
                divider_reset <= wr_clk_r;
                wr_clk_r <= 1'b0;
            end else begin
                case (state_r)
                    ST_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    ST_ADDR: begin
                        if (scl_rise) begin
                            shift_r <= {shift_r[6:0], sda_in};
                            bit_r <= bit_r + 4'h1;
                        end else if (scl_fall && bit_r == 4'h8) begin
                            if (shift_r[7:1] == `RTCS_SLAVE_ADDR) begin
                                sda_oe <= 1'b1;
                                rd_mode_r <= shift_r[0];
                                ptr_phase_r <= !shift_r[0];
                                state_r <= ST_AACK;
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end
                    end
                    ST_AACK: begin
                        if (scl_fall) begin
                            bit_r <= 4'h0;
                            if (rd_mode_r) begin
                                // Read starts at the held pointer
                                shift_r <= reg_rdata;
                                sda_oe <= !reg_rdata[7];
                                update_freeze <= (ptr_r <=
                                    `RTCS_LAST_CLK_LOC);
                                state_r <= ST_TX;
                            end else begin
                                sda_oe <= 1'b0;
                                state_r <= ST_RX;
                            end
                        end
                    end
                    ST_RX: begin
                        if (scl_rise) begin
                            shift_r <= {shift_r[6:0], sda_in};
                            bit_r <= bit_r + 4'h1;
                        end else if (scl_fall && bit_r == 4'h8) begin
                            // Full FIFO or recovery: no acknowledge, no store
                            if (ptr_phase_r) begin
                                ptr_r <= (shift_r[4:0] > `RTCS_LAST_LOC) ?
                                    `RTCS_PTR_RST : shift_r[4:0];
                                update_freeze <= (shift_r[4:0] <=
                                    `RTCS_LAST_CLK_LOC);
                                sda_oe <= 1'b1;
                                state_r <= ST_RACK;
                            end else if (!wp_block_r && fifo_ready &&
                                !fifo_valid_r) begin
                                fifo_in_r <= {ptr_r, shift_r};
                                fifo_valid_r <= 1'b1;
                                if (ptr_r <= `RTCS_LAST_CLK_LOC) begin
                                    wr_clk_r <= 1'b1;
                                end
                                sda_oe <= 1'b1;
                                state_r <= ST_RACK;
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_fall) begin
                            sda_oe <= 1'b0;
                            bit_r <= 4'h0;
                            if (!ptr_phase_r) begin
                                ptr_r <= ptr_inc;
                                update_freeze <= (ptr_inc <=
                                    `RTCS_LAST_CLK_LOC);
                            end
                            ptr_phase_r <= 1'b0;
                            state_r <= ST_RX;
                        end
                    end
                    ST_TX: begin
                        if (scl_rise) begin
                            bit_r <= bit_r + 4'h1;
                            if (bit_r == 4'h8) begin
                                // Master acknowledge rides the ninth pulse
                                mack_r <= !sda_in;
                            end
                        end else if (scl_fall && bit_r == 4'h8) begin
                            sda_oe <= 1'b0;
                        end else if (scl_fall && bit_r == 4'h9) begin
                            ptr_r <= ptr_inc;
                            update_freeze <= (ptr_inc <=
                                `RTCS_LAST_CLK_LOC);
                            bit_r <= 4'h0;
                            fetch_r <= 1'b0;
                            if (mack_r) begin
                                state_r <= ST_FETCH;
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end else if (scl_fall) begin
                            sda_oe <= !shift_r[6];
                            shift_r <= {shift_r[6:0], 1'b0};
                        end
                    end
                    ST_FETCH: begin
                        // Second cycle: reg_addr and reg_rdata follow ptr_r
                        if (fetch_r) begin
                            shift_r <= reg_rdata;
                            sda_oe <= !reg_rdata[7];
                            fetch_r <= 1'b0;
                            state_r <= ST_TX;
                        end else begin
                            fetch_r <= 1'b1;
                        end
                    end
                    default: begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Multi-function output
    // ------------------------------------------------------------------
    // Open drain pin: oe high pulls it low. The square wave
    // overrides every other source.
    always @(posedge core_clk) begin
        if (srst) begin
            multi_function_output_oe <= 1'b0;
        end else if (sqw_enable) begin
            multi_function_output_oe <= !sqw_level;
        end else begin
            multi_function_output_oe <= alt_out_low;
        end
    end
endmodule // rtcs_slave
`default_nettype wire

// File: test/rtcs_slave_assertions.sv
// Concurrent checks on the serial slave front end ports.
// Assumes binding onto rtcs_slave; one clock, srst active high.
`timescale 1ns/100ps
`default_nettype none
module rtcs_slave_chk (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic power_fail,
    input wire logic [4:0] reg_addr,
    input wire logic update_freeze,
    input wire logic divider_reset,
    input wire logic sqw_enable,
    input wire logic sqw_level,
    input wire logic alt_out_low,
    input wire logic multi_function_output_oe
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);
    // -----------------------------
    // Bus conditions
    // -----------------------------
    sequence stop_s;
        scl_in && !sda_in ##1 scl_in && sda_in;
    endsequence
    sequence pf_s;
        power_fail [*3];
    endsequence
    a_sda_drive_low: assert property (sda_out == 1'b0)
        else $error("sda driven high");
    a_ptr_in_range: assert property (reg_addr <= 5'h13)
        else $error("pointer out of range");
    a_pf_release: assert property (pf_s |-> !sda_oe)
        else $error("sda held in power fail");
    a_pf_ptr_clear: assert property (pf_s |-> reg_addr == 5'h00)
        else $error("pointer kept in power fail");
    a_oe_scl_low: assert property ($changed(sda_oe)
        && !$past(power_fail) |-> !scl_in && !$past(scl_in))
        else $error("sda changed while scl high");
    a_stop_thaw: assert property (stop_s |-> ##[1:3] !update_freeze)
        else $error("freeze kept after stop");
    a_data_area_thaw: assert property ((reg_addr > 5'h07) [*3]
        |-> !$past(update_freeze))
        else $error("freeze outside clock area");
    a_div_one_pulse: assert property (divider_reset |=> !divider_reset)
        else $error("divider reset too long");
    a_mfo_sqw_first: assert property (sqw_enable
        |=> multi_function_output_oe == !$past(sqw_level))
        else $error("square wave not first");
    a_mfo_alt_src: assert property (!sqw_enable
        |=> multi_function_output_oe == $past(alt_out_low))
        else $error("output source wrong");
endmodule // rtcs_slave_chk
bind rtcs_slave rtcs_slave_chk rtcs_slave_chk_inst (.core_clk, .srst,
    .scl_in, .sda_in, .sda_out, .sda_oe, .power_fail, .reg_addr,
    .update_freeze, .divider_reset, .sqw_enable, .sqw_level, .alt_out_low,
    .multi_function_output_oe);
`default_nettype wire

// File: test/rtcs_master_model.sv
// Behavioural two-wire bus master: drives SCL, pulls SDA low or lets go.
// Assumes a pull-up on SDA outside; one bit lasts three half periods.
`timescale 1ns/100ps
`default_nettype none
module rtcs_master_model #(
    parameter int HALF = 4
) (
    input wire logic core_clk,
    input wire logic sda_line,
    output var logic scl,
    output var logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick;
        repeat (HALF) @(posedge core_clk);
        #1;
    endtask
    // -----------------------------
    // Bus conditions and bits
    // -----------------------------
    task automatic start;
        sda_low = 1'b0;
        tick;
        scl = 1'b1;
        tick;
        sda_low = 1'b1;
        tick;
        scl = 1'b0;
        tick;
    endtask
    task automatic stop;
        sda_low = 1'b1;
        tick;
        scl = 1'b1;
        tick;
        sda_low = 1'b0;
        tick;
    endtask
    // Sampled late in the high phase, after the slave has settled
    task automatic bitx(input logic b, output logic r);
        sda_low = ~b;
        tick;
        scl = 1'b1;
        tick;
        r = sda_line;
        scl = 1'b0;
        tick;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitx(d[i], r);
        bitx(1'b1, r);
        ack = ~r;
    endtask
    // No acknowledge on the last byte, so the slave lets SDA go
    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitx(1'b1, d[i]);
        bitx(~ack, r);
    endtask
endmodule // rtcs_master_model
`default_nettype wire

// File: test/test_rtcs_slave.sv
// Self-checking bench for rtcs_slave with a bus master model.
// Assumes the FIFO is inside the slave; the bench acts as register store.
`timescale 1ns/100ps
`default_nettype none
module test_rtcs_slave;
    localparam int WP = 400;
    logic core_clk = 0, srst = 1, pf = 0, wr_ready = 1;
    logic sqe = 0, sql = 0, alo = 0;
    logic scl, m_low, sda_oe, wr_valid, frz, divr, mfo;
    logic [4:0] ra, wa;
    logic [7:0] wd, mem [0:19];
    wire logic sda;
    int n_errors = 0, checks = 0, cyc = 0, ndiv = 0;
    assign sda = ~(m_low | sda_oe);
    always #50 core_clk = ~core_clk;
    rtcs_slave #(.WP_CYCLES(WP)) rtcs_slave_inst (.core_clk(core_clk),
        .srst(srst), .scl_in(scl), .sda_in(sda), .sda_out(),
        .sda_oe(sda_oe), .power_fail(pf), .reg_addr(ra),
        .reg_rdata(mem[ra]), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_addr(wa), .wr_data(wd), .update_freeze(frz),
        .divider_reset(divr), .sqw_enable(sqe), .sqw_level(sql),
        .alt_out_low(alo), .multi_function_output_oe(mfo));
    rtcs_master_model #(.HALF(4)) rtcs_master_model_inst (
        .core_clk(core_clk), .sda_line(sda), .scl(scl), .sda_low(m_low));
    always @(posedge core_clk) begin
        if (wr_valid && wr_ready)
            mem[wa] <= wd;
        if (divr)
            ndiv <= ndiv + 1;
        cyc <= cyc + 1;
        // Whole run needs well under this
        if (cyc == 20000) begin
            n_errors++;
            stop_test;
        end
    end
    // -----------------------------
    // Helpers
    // -----------------------------
    task automatic stop_test;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %0t byte %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %0t flag %b exp %b", $time, g, e);
        end
    endtask
    task automatic wb(input logic [7:0] d, input logic e);
        logic a;
        rtcs_master_model_inst.wbyte(d, a);
        chk1(a, e);
    endtask
    task automatic rb(input logic a, input logic [7:0] e);
        logic [7:0] d;
        rtcs_master_model_inst.rbyte(a, d);
        chk8(d, e);
    endtask
    task automatic st;
        rtcs_master_model_inst.start;
    endtask
    task automatic sp;
        rtcs_master_model_inst.stop;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // -----------------------------
    // Scenarios
    // -----------------------------
    task automatic t_wr_rd;
        st;
        wb(8'hd0, 1'b1);
        wb(8'h12, 1'b1);
        wb(8'h5a, 1'b1);
        wb(8'h3c, 1'b1);
        sp;
        st;
        wb(8'hd0, 1'b1);
        wb(8'h12, 1'b1);
        st;
        wb(8'hd1, 1'b1);
        rb(1'b1, 8'h5a);
        rb(1'b1, 8'h3c);
        rb(1'b0, 8'h80);
        sp;
    endtask
    task automatic t_fifo;
        wr_ready = 1'b0;
        st;
        wb(8'hd0, 1'b1);
        wb(8'h08, 1'b1);
        for (int i = 0; i < 9; i++)
            wb(8'h40 + i[7:0], i < 8);
        sp;
        wr_ready = 1'b1;
        wait_cyc(20);
        chk8(mem[8], 8'h40);
        chk8(mem[15], 8'h47);
    endtask
    task automatic t_div;
        st;
        wb(8'hd0, 1'b1);
        wb(8'h02, 1'b1);
        wb(8'h11, 1'b1);
        sp;
        wait_cyc(5);
        chk8(ndiv[7:0], 8'h01);
    endtask
    task automatic t_alt;
        st;
        wb(8'hd0, 1'b1);
        wb(8'h05, 1'b1);
        chk1(frz, 1'b1);
        sp;
        st;
        wb(8'hd1, 1'b1);
        rb(1'b0, 8'h85);
        sp;
        chk1(frz, 1'b0);
    endtask
    task automatic t_bad;
        logic b;
        st;
        wb(8'ha0, 1'b0);
        sp;
        st;
        repeat (3) rtcs_master_model_inst.bitx(1'b1, b);
        st;
        wb(8'hd0, 1'b1);
        sp;
    endtask
    task automatic t_mfo;
        for (int i = 0; i < 8; i++) begin
            {sqe, sql, alo} = i[2:0];
            wait_cyc(1);
            chk1(mfo, sqe ? ~sql : alo);
        end
    endtask
    task automatic t_pf;
        st;
        wb(8'hd0, 1'b1);
        wb(8'h06, 1'b1);
        pf = 1'b1;
        sp;
        wait_cyc(10);
        pf = 1'b0;
        wait_cyc(WP + 100);
        st;
        wb(8'hd1, 1'b1);
        rb(1'b0, 8'h80);
        sp;
        pf = 1'b1;
        wait_cyc(10);
        pf = 1'b0;
        st;
        wb(8'hd0, 1'b1);
        wb(8'h09, 1'b1);
        wb(8'h77, 1'b0);
        sp;
    endtask
    initial begin
        for (int i = 0; i < 20; i++)
            mem[i] = 8'h80 + i[7:0];
        wait_cyc(4);
        srst = 1'b0;
        t_wr_rd;
        t_fifo;
        t_div;
        t_alt;
        t_bad;
        t_mfo;
        t_pf;
        stop_test;
    end
endmodule // test_rtcs_slave
`default_nettype wire
